// [test/sdm_clock_mux_props.sv]
// Purpose: port-level properties of the sigma-delta clock and multiplex block
// Assumes: one clk domain, resetn async active low
// Notes: output flops lag ext_clk by one clk, so phases are read from conv_clk_a
module sdm_clock_mux_props (
  input wire clk,
  input wire resetn,
  input wire ext_clk,
  input wire gain_select_pin,
  input wire out_hold,
  input wire mux_bit_out,
  input wire mux_bit_out_inv,
  input wire current_gain_x32,
  input wire [1:0] ref_tc_sel,
  input wire conv_clk_a,
  input wire conv_clk_b,
  input wire chop_v,
  input wire chop_c_a,
  input wire chop_c_b,
  input wire sw_phase1,
  input wire sw_phase2,
  input wire sample_overrun
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_inv_pair: assert property (mux_bit_out_inv != mux_bit_out)
    else $error("inverted output equals output");
  chk_gain_high: assert property (gain_select_pin |=> current_gain_x32)
    else $error("gain pin high but x8 selected");
  chk_gain_low: assert property (!gain_select_pin |=> !current_gain_x32)
    else $error("gain pin low but x32 selected");
  chk_conv_follow: assert property (ext_clk |=> conv_clk_a && !conv_clk_b)
    else $error("conversion clocks do not follow ext clock");
  chk_chop_inv: assert property ($past(resetn) |-> chop_c_b != chop_c_a)
    else $error("current chop clocks not complementary");
  chk_chop_v_step: assert property ($rose(conv_clk_a) |=> $changed(chop_v))
    else $error("voltage chop clock did not step");
  chk_phase_excl: assert property (!(sw_phase1 && sw_phase2))
    else $error("switch phases overlap");
  chk_mux_stable: assert property (conv_clk_a == $past(conv_clk_a)
    |-> $stable(mux_bit_out)) else $error("output moved inside a phase");
  chk_overrun_hold: assert property ($rose(sample_overrun) |-> $past(out_hold))
    else $error("pair lost while buffer drained");
  chk_release_idle: assert property ($rose(resetn) |-> !mux_bit_out
    && ref_tc_sel == 2'h0) else $error("outputs not idle in reset");
endmodule

bind sdm_clock_mux sdm_clock_mux_props chk_u (.clk(clk), .resetn(resetn),
  .ext_clk(ext_clk), .gain_select_pin(gain_select_pin), .out_hold(out_hold),
  .mux_bit_out(mux_bit_out), .mux_bit_out_inv(mux_bit_out_inv),
  .current_gain_x32(current_gain_x32), .ref_tc_sel(ref_tc_sel),
  .conv_clk_a(conv_clk_a), .conv_clk_b(conv_clk_b), .chop_v(chop_v), .chop_c_a(chop_c_a),
  .chop_c_b(chop_c_b), .sw_phase1(sw_phase1), .sw_phase2(sw_phase2),
  .sample_overrun(sample_overrun));

// [test/sdm_dsp_model.sv]
// Purpose: far-side model that clocks the converter and splits its stream
// Assumes: HALF clk cycles per phase; 5 gives 1 MHz, close to the low rate
// Notes: samples late in each phase so the one-clk output lag has settled
module sdm_dsp_model #(parameter int HALF = 5) (
  input wire logic clk,
  input wire logic run,
  input wire logic mux_bit,
  output logic ext_clk,
  output logic got,
  output logic [1:0] pair
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial begin
    ext_clk = 1'b0;
    got = 1'b0;
    pair = 2'h0;
  end
  always @(posedge clk) begin
    got <= 1'b0;
    if (run) begin
      cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
      ext_clk <= (cnt < HALF);
      if (cnt == HALF - 1) pair[1] <= mux_bit;
      if (cnt == 2 * HALF - 1) begin
        pair[0] <= mux_bit;
        got <= 1'b1;
      end
    end
  end
endmodule

// [test/test_sdm_clock_mux.sv]
// Purpose: self-checking bench for the sigma-delta clock and multiplex block
// Assumes: 10 MHz clk, far-side model pacing ext_clk
// Notes: a pair written at a fall comes back two periods later
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_sdm_clock_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, run = 0, en = 0, v_bs = 0, c_bs = 0, gain = 0;
  logic trim = 0, hold = 0, got, ext_clk, mux, mux_inv, gx32, ovr;
  logic [1:0] tc, pair, exp_p, rnd;
  logic [1:0] exp_q[$];
  int err_total = 0, cmp_count = 0, cyc = 0, skip = 2, tmode = 0;
  always #50 clk = ~clk;
  sdm_dsp_model dsp_u (.clk(clk), .run(run), .mux_bit(mux), .ext_clk(ext_clk),
    .got(got), .pair(pair));
  sdm_clock_mux dut_u (.clk(clk), .resetn(resetn), .ext_clk(ext_clk),
    .voltage_bitstream(v_bs), .current_bitstream(c_bs), .gain_select_pin(gain),
    .reference_trim_pin(trim), .out_hold(hold), .mux_bit_out(mux),
    .mux_bit_out_inv(mux_inv), .current_gain_x32(gx32), .ref_tc_sel(tc),
    .conv_clk_a(), .conv_clk_b(), .chop_v(), .chop_c_a(), .chop_c_b(),
    .sw_phase1(), .sw_phase2(), .sw_chop_v(), .sw_chop_c(), .sample_overrun(ovr));
  // trim pin follows the sampled ext clock, so it lags by one clk
  always @(posedge clk)
    trim <= (tmode == 0) ? 1'b0 : (tmode == 3) ? 1'b1 : (tmode == 1) ? ext_clk : !ext_clk;
  always @(posedge clk) begin
    if (got && en) begin
      if (skip > 0) skip--;
      else if (exp_q.size() > 0) begin
        exp_p = exp_q.pop_front();
        `CHK(pair, exp_p)
      end
    end
  end
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h7623C334));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    run <= 1'b1;
    en <= 1'b1;
    repeat (60) begin
      @(negedge ext_clk);
      @(posedge clk);
      rnd = 2'($urandom);
      v_bs <= rnd[1];
      c_bs <= rnd[0];
      exp_q.push_back(rnd);
    end
    repeat (3) @(negedge ext_clk);
    `CHK(exp_q.size(), 0)
    en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      tmode <= i;
      gain <= i[0];
      repeat (3) @(negedge ext_clk);
      `CHK(tc, 2'(i))
      `CHK(gx32, i[0])
      `CHK(mux_inv, !mux)
    end
    hold <= 1'b1;
    repeat (40) @(negedge ext_clk);
    `CHK(ovr, 1'b1)
    hold <= 1'b0;
    repeat (3) @(negedge ext_clk);
    test_done();
  end
endmodule

// [verilog/sdm_clock_mux.v]
// Purpose: digital part of a dual-channel first-order sigma-delta modulator
// Assumes: ext_clk and all pins synchronous to clk (10 MHz), ext_clk much slower
// Notes: resetn is the supply-level power-on reset
//   out_hold and sample_overrun are test and status additions
//   derived clocks are registered; conv_clk_a and conv_clk_b run one clk behind ext_clk, the chop clocks two
//
// Notes on behaviour
// - all digital timing referenced to ext clock
// - two parallel channels, each one-bit stream
// - both streams interleaved onto one output
// - sampling and interleaving paced by ext clock
// - voltage gain x4, current x8 or x32
// - configured only by two static pins
// - power-on reset holds all functions
// - five clocks derived from ext clock
// - control module makes all switch controls
// - output voltage bit when high, current when low
// - gain pin low x8, high x32
// - trim pin four states pick reference setting
`include "sdm_regs.vh"

// ----------------------------------------
// stream buffer
// ----------------------------------------
module sdm_fifo #(
  parameter WIDTH = `SDM_PAIR_W,
  parameter DEPTH = `SDM_FIFO_DEPTH,
  parameter AW = `SDM_FIFO_AW
) (
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_q;
  reg [AW:0] rd_ptr_q;
  wire do_wr;
  wire do_rd;

  assign in_ready = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign out_data = mem[rd_ptr_q[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage needs no reset; the pointers guard every read
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // one extra pointer bit tells a full buffer from an empty one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= {(AW+1){1'b0}};
    end else if (do_wr) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_ptr_q <= {(AW+1){1'b0}};
    end else if (do_rd) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule

// ----------------------------------------
// top level
// ----------------------------------------
module sdm_clock_mux (
  input wire clk,
  input wire resetn,
  input wire ext_clk,
  input wire voltage_bitstream,
  input wire current_bitstream,
  input wire gain_select_pin,
  input wire reference_trim_pin,
  input wire out_hold,
  output reg mux_bit_out,
  output reg mux_bit_out_inv,
  output reg current_gain_x32,
  output reg [1:0] ref_tc_sel,
  output reg conv_clk_a,
  output reg conv_clk_b,
  output reg chop_v,
  output reg chop_c_a,
  output reg chop_c_b,
  output reg sw_phase1,
  output reg sw_phase2,
  output reg sw_chop_v,
  output reg sw_chop_c,
  output reg sample_overrun
);
  // ----------------------------------------
  // ext clock edge tracking
  // ----------------------------------------
  reg ext_q;
  reg [1:0] div_q;
  reg trim_hi_q;
  reg pend_valid_q;
  reg [`SDM_PAIR_W-1:0] pend_q;
  reg [`SDM_PAIR_W-1:0] cur_q;
  wire ext_rise;
  wire ext_fall;
  wire f_in_ready;
  wire f_out_valid;
  wire [`SDM_PAIR_W-1:0] f_out_data;
  wire f_out_ready;
  wire [`SDM_PAIR_W-1:0] cur_d;

  assign ext_rise = ext_clk && !ext_q;
  assign ext_fall = !ext_clk && ext_q;
  // out_hold lets the drain stall so the buffer can really fill
  assign f_out_ready = ext_rise && !out_hold;
  // a held out_hold drains nothing, so the buffer fills within 32 periods
  // a pair popped at a rising edge goes straight to the output, so each
  // phase carries bits of one pair only
  assign cur_d = (f_out_ready && f_out_valid) ? f_out_data : cur_q;

  // ----------------------------------------
  // stream capture and buffer
  // ----------------------------------------
  // previous ext clock sample, for edge detection
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_clk;
    end
  end

  // both channels captured together at each rising ext edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_valid_q <= 1'b0;
      pend_q <= {`SDM_PAIR_W{1'b0}};
    end else if (ext_rise) begin
      pend_q <= {voltage_bitstream, current_bitstream};
      pend_valid_q <= 1'b1;
    end else if (f_in_ready) begin
      pend_valid_q <= 1'b0;
    end
  end

  // a pair still waiting is overwritten: the stream cannot pause
  // the flag stands for one period, until the next rising edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_overrun <= 1'b0;
    end else if (ext_rise) begin
      sample_overrun <= pend_valid_q && !f_in_ready;
    end
  end

  // the buffer absorbs the gap between capture and the drain at the next rise
  // in_valid is masked at a rise so a pair never writes while it is replaced
  sdm_fifo #(
    .WIDTH(`SDM_PAIR_W),
    .DEPTH(`SDM_FIFO_DEPTH),
    .AW(`SDM_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(pend_valid_q && !ext_rise),
    .in_ready(f_in_ready),
    .in_data(pend_q),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ----------------------------------------
  // output multiplex
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_q <= {`SDM_PAIR_W{1'b0}};
    end else begin
      cur_q <= cur_d;
    end
  end

  // one shared pin carries both channels, split by ext clock phase
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mux_bit_out <= 1'b0;
      mux_bit_out_inv <= 1'b1;
    end else if (ext_clk) begin
      mux_bit_out <= cur_d[`SDM_PAIR_V_BIT];
      mux_bit_out_inv <= !cur_d[`SDM_PAIR_V_BIT];
    end else begin
      mux_bit_out <= cur_d[`SDM_PAIR_C_BIT];
      mux_bit_out_inv <= !cur_d[`SDM_PAIR_C_BIT];
    end
  end

  // ----------------------------------------
  // mode decoder
  // ----------------------------------------
  // gain pin is static, so one register stage is enough
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      current_gain_x32 <= `SDM_GAIN_X8;
    end else begin
      current_gain_x32 <= gain_select_pin ? `SDM_GAIN_X32 : `SDM_GAIN_X8;
    end
  end

  // trim pin is seen once per phase; the pair of samples names its state
  // high-phase sample, taken at the fall
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trim_hi_q <= 1'b0;
    end else if (ext_fall) begin
      trim_hi_q <= reference_trim_pin;
    end
  end

  // a change of trim mode takes up to one and a half periods to be seen
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_tc_sel <= `SDM_TC_HELD_LOW;
    end else if (ext_rise) begin
      case ({trim_hi_q, reference_trim_pin})
        2'h0: ref_tc_sel <= `SDM_TC_HELD_LOW;
        2'h2: ref_tc_sel <= `SDM_TC_FOLLOW_CLK;
        2'h1: ref_tc_sel <= `SDM_TC_FOLLOW_INVERTED_CLOCK;
        2'h3: ref_tc_sel <= `SDM_TC_HELD_HIGH;
        default: ref_tc_sel <= `SDM_TC_HELD_LOW;
      endcase
    end
  end

  // ----------------------------------------
  // clock generator and switch controls
  // ----------------------------------------
  // limitation: ext_clk must stay at each level for at least two clk
  // divider for the chopper clocks
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 2'h0;
    end else if (ext_rise) begin
      div_q <= div_q + 2'h1;
    end
  end

  // conversion clocks are the ext clock and its complement
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_clk_a <= 1'b0;
      conv_clk_b <= 1'b0;
    end else begin
      conv_clk_a <= ext_clk;
      conv_clk_b <= !ext_clk;
    end
  end

  // chopping at ext/2 and ext/4 moves amplifier offset out of the signal band
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chop_v <= 1'b0;
      chop_c_a <= 1'b0;
      chop_c_b <= 1'b0;
    end else begin
      chop_v <= div_q[0];
      chop_c_a <= div_q[1];
      chop_c_b <= !div_q[1];
    end
  end

  // phases skip the edge cycle so they never overlap
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_phase1 <= 1'b0;
      sw_phase2 <= 1'b0;
    end else begin
      sw_phase1 <= ext_clk && ext_q;
      sw_phase2 <= !ext_clk && !ext_q;
    end
  end

  // chop switch controls, registered so they cannot glitch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_chop_v <= 1'b0;
      sw_chop_c <= 1'b0;
    end else begin
      sw_chop_v <= div_q[0];
      sw_chop_c <= div_q[1] ^ div_q[0];
    end
  end
endmodule

// [verilog/sdm_regs.vh]
// Purpose: constants shared by the sigma-delta clock and multiplex logic
// Assumes: plain Verilog-2005 includes
// Notes: no software registers exist; configuration arrives on static pins
`ifndef SDM_REGS_VH
`define SDM_REGS_VH

// ----------------------------------------
// stream buffer shape
// ----------------------------------------
`define SDM_PAIR_W 2
`define SDM_FIFO_DEPTH 32
`define SDM_FIFO_AW 5
`define SDM_PAIR_V_BIT 1
`define SDM_PAIR_C_BIT 0

// ----------------------------------------
// reference temperature-coefficient codes
// ----------------------------------------
`define SDM_TC_HELD_LOW 2'h0
`define SDM_TC_FOLLOW_CLK 2'h1
`define SDM_TC_FOLLOW_INVERTED_CLOCK 2'h2
`define SDM_TC_HELD_HIGH 2'h3

// ----------------------------------------
// current channel gain codes
// ----------------------------------------
`define SDM_GAIN_X8 1'h0
`define SDM_GAIN_X32 1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define SDM_SYS_CLK_KHZ 10000
`define SDM_EXT_CLK_LOW_KHZ 1024
`define SDM_EXT_CLK_HIGH_KHZ 2048

`endif
